// ==== logic/uar_pkg.sv ====
// Package: register map, field positions and constants of the serial receiver
package uar_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_IRQ_FLAGS_A   = 8'h0C;
	localparam logic [7:0] IDX_RX_STATUS_CTL = 8'h18;
	localparam logic [7:0] IDX_TX_BUFFER     = 8'h19;
	localparam logic [7:0] IDX_RX_BUFFER     = 8'h1A;
	localparam logic [7:0] IDX_IRQ_ENABLES_A = 8'h8C;
	localparam logic [7:0] IDX_TX_STATUS_CTL = 8'h98;
	localparam logic [7:0] IDX_BAUD_DIVISOR  = 8'h99;

	// ==========================================================
	// Receive status/control fields
	localparam int RCS_PORT_EN   = 7;
	localparam int RCS_NINE_SEL  = 6;
	localparam int RCS_SINGLE_EN = 5;
	localparam int RCS_CONT_EN   = 4;
	localparam int RCS_FRAME_ERR = 2;
	localparam int RCS_OVERRUN   = 1;
	localparam int RCS_NINTH     = 0;

	// ==========================================================
	// Transmit status/control fields
	localparam int TCS_CLK_MASTER = 7;
	localparam int TCS_NINE_SEL   = 6;
	localparam int TCS_TX_EN      = 5;
	localparam int TCS_SYNC_SEL   = 4;
	localparam int TCS_HIGH_BAUD  = 2;
	localparam int TCS_SHIFT_IDLE = 1;
	localparam int TCS_TX_NINTH   = 0;

	// ==========================================================
	// Interrupt flag / enable fields
	localparam int IRQ_RX_PENDING = 5;

	// ==========================================================
	// Reset values and writable masks
	localparam logic [7:0] RST_BYTE      = 8'h00;
	localparam logic [7:0] RST_TX_STATUS = 8'h02;
	localparam logic [7:0] RCS_WR_MASK   = 8'hF0;
	localparam logic [7:0] TCS_WR_MASK   = 8'hF5;

	// ==========================================================
	// Bit recovery timing on the x16 tick
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
	localparam logic [3:0] VOTE_FIRST      = 4'h7;
	localparam logic [3:0] VOTE_MID        = 4'h8;
	localparam logic [3:0] VOTE_LAST       = 4'h9;
	localparam logic [3:0] DATA_BITS_8     = 4'h8;
	localparam logic [3:0] DATA_BITS_9     = 4'h9;
	localparam logic [1:0] LOW_SPEED_MUL   = 2'h3;

	// ==========================================================
	// Receiver states
	typedef enum logic [1:0] {
		UAR_IDLE,
		UAR_START,
		UAR_DATA,
		UAR_STOP
	} uar_state_t;

endpackage

// ==== logic/uar_receiver.sv ====
// Serial port receive path, mode control and APB register file
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - bits recovered by x16 oversampling; shift register advances once per bit.
// - asynchronous frames accepted only while continuous receive enable is set.
// - after the stop bit the word moves to the buffer if space exists.
// - transfer sets receive pending; interrupt raised only with its enable.
// - receive pending is read-only, cleared when reads empty the buffer.
// - receive buffer is a two-entry FIFO; two reads return both words.
// - stop bit with full FIFO sets overrun and discards the shifted word.
// - overrun clears only by clearing then setting continuous receive enable.
// - while overrun is set no word enters the FIFO.
// - framing error marks a word whose stop bit sampled low.
// - framing and ninth bit travel with data; each read shows next entry.
// - nine-bit select captures a ninth bit shown in the status field.
// - synchronous master mode is half-duplex, receive and transmit exclusive.
// - synchronous select in transmit control chooses synchronous or asynchronous.
// - serial port enable hands the two pins to the serial function.
// - clock source select makes the block drive the shift clock.
// - frame is start, eight or nine LSB-first data bits, stop; no parity.
// - each bit decided by majority of samples seven, eight, nine.
module uar_receiver #(
	parameter int DIV_WIDTH = 10
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        receive_data_pin_i,
	output logic             receive_data_pin_o,
	output logic             receive_data_pin_oe,
	input  wire logic        transmit_clock_pin_i,
	output logic             transmit_clock_pin_o,
	output logic             transmit_clock_pin_oe,
	output logic             rx_irq,
	output logic             tx_permit
);

	// ==========================================================
	// Declarations
	logic [7:0]                rx_ctl_reg;
	logic [7:0]                tx_ctl_reg;
	logic [7:0]                irq_en_reg;
	logic [7:0]                baud_div_reg;
	logic [7:0]                tx_buf_reg;
	logic [31:0]               prdata_reg;
	logic                      overrun_reg;
	logic                      cont_en_d_reg;
	logic [1:0]                rx_sync_reg;
	logic                      rx_prev_reg;
	logic [DIV_WIDTH-1:0]      div_cnt_reg;
	logic                      tick16;
	logic                      sclk_phase_reg;
	logic                      sclk_reg;
	uar_pkg::uar_state_t       state_reg;
	logic [3:0]                phase_reg;
	logic [3:0]                bit_cnt_reg;
	logic [2:0]                votes_reg;
	logic [8:0]                shift_reg;
	logic [9:0]                fifo_mem [0:1];
	logic                      rd_ptr_reg;
	logic                      wr_ptr_reg;
	logic [1:0]                count_reg;
	logic                      setup_phase;
	logic                      access_done;
	logic                      wr_en;
	logic                      rd_en;
	logic [7:0]                reg_idx;
	logic                      mapped;
	logic                      port_en;
	logic                      sync_mode;
	logic                      async_rx_on;
	logic                      sync_rx_on;
	logic                      pop;
	logic                      word_done;
	logic                      push;
	logic                      vote_bit;
	logic [9:0]                head;
	logic [DIV_WIDTH-1:0]      reload;
	logic [3:0]                data_bits;

	// ==========================================================
	// Helper functions

	// Majority of three samples
	function automatic logic majority3(input logic [2:0] s);
		majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	// Word index of a bus address; registers sit on aligned words
	function automatic logic [7:0] word_index(input logic [31:0] a);
		word_index = a[9:2];
	endfunction

	// True when the index names a register of this block
	function automatic logic is_mapped(input logic [31:0] a);
		logic [7:0] i;
		i = word_index(a);
		is_mapped = (a[31:10] == 22'h0) && (a[1:0] == 2'h0) &&
			(i == uar_pkg::IDX_IRQ_FLAGS_A || i == uar_pkg::IDX_RX_STATUS_CTL ||
			 i == uar_pkg::IDX_TX_BUFFER || i == uar_pkg::IDX_RX_BUFFER ||
			 i == uar_pkg::IDX_IRQ_ENABLES_A || i == uar_pkg::IDX_TX_STATUS_CTL ||
			 i == uar_pkg::IDX_BAUD_DIVISOR);
	endfunction

	// ==========================================================
	// APB decode; the slave never waits, so pready is simply high
	assign reg_idx     = word_index(paddr);
	assign mapped      = is_mapped(paddr);
	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable;
	assign wr_en       = access_done & pwrite & mapped & pstrb[0];
	assign rd_en       = access_done & ~pwrite & mapped;
	assign pready      = 1'b1;
	assign pslverr     = access_done & ~mapped;
	assign prdata      = prdata_reg;

	// ==========================================================
	// Mode selection
	assign port_en   = rx_ctl_reg[uar_pkg::RCS_PORT_EN];
	assign sync_mode = tx_ctl_reg[uar_pkg::TCS_SYNC_SEL];
	assign async_rx_on = port_en & ~sync_mode & rx_ctl_reg[uar_pkg::RCS_CONT_EN];
	assign sync_rx_on  = port_en & sync_mode &
		(rx_ctl_reg[uar_pkg::RCS_CONT_EN] | rx_ctl_reg[uar_pkg::RCS_SINGLE_EN]);
	assign tx_permit = tx_ctl_reg[uar_pkg::TCS_TX_EN] & ~sync_rx_on;

	// ==========================================================
	// Pin ownership
	// port enable, synchronous select and clock source select claim the clock pin
	assign transmit_clock_pin_oe = port_en & sync_mode & tx_ctl_reg[uar_pkg::TCS_CLK_MASTER];
	assign transmit_clock_pin_o  = sclk_reg;
	// Data line is released while receiving; idle level high when transmit may drive it
	assign receive_data_pin_oe = port_en & sync_mode & tx_permit;
	assign receive_data_pin_o  = 1'b1;

	// ==========================================================
	// Register writes and configuration
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_ctl_reg   <= uar_pkg::RST_BYTE;
			tx_ctl_reg   <= uar_pkg::RST_TX_STATUS;
			irq_en_reg   <= uar_pkg::RST_BYTE;
			baud_div_reg <= uar_pkg::RST_BYTE;
			tx_buf_reg   <= uar_pkg::RST_BYTE;
		end else if (wr_en) begin
			case (reg_idx)
				uar_pkg::IDX_RX_STATUS_CTL: begin
					rx_ctl_reg <= pwdata[7:0] & uar_pkg::RCS_WR_MASK;
				end
				uar_pkg::IDX_TX_STATUS_CTL: begin
					tx_ctl_reg <= (pwdata[7:0] & uar_pkg::TCS_WR_MASK) |
						uar_pkg::RST_TX_STATUS;
				end
				uar_pkg::IDX_IRQ_ENABLES_A: begin
					irq_en_reg <= pwdata[7:0];
				end
				uar_pkg::IDX_BAUD_DIVISOR: begin
					baud_div_reg <= pwdata[7:0];
				end
				uar_pkg::IDX_TX_BUFFER: begin
					tx_buf_reg <= pwdata[7:0];
				end
				default: begin
					tx_buf_reg <= tx_buf_reg;
				end
			endcase
		end
	end

	// ==========================================================
	// Read data captured in the setup phase so prdata is a flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_reg <= 32'h0000_0000;
		end else if (setup_phase && !pwrite) begin
			prdata_reg <= 32'h0000_0000;
			case (reg_idx)
				uar_pkg::IDX_IRQ_FLAGS_A: begin
					prdata_reg[uar_pkg::IRQ_RX_PENDING] <= (count_reg != 2'h0);
				end
				uar_pkg::IDX_RX_STATUS_CTL: begin
					prdata_reg[7:0] <= rx_ctl_reg;
					prdata_reg[uar_pkg::RCS_FRAME_ERR] <= head[9];
					prdata_reg[uar_pkg::RCS_OVERRUN]   <= overrun_reg;
					prdata_reg[uar_pkg::RCS_NINTH]     <= head[8];
				end
				uar_pkg::IDX_TX_BUFFER:     prdata_reg[7:0] <= tx_buf_reg;
				uar_pkg::IDX_RX_BUFFER:     prdata_reg[7:0] <= head[7:0];
				uar_pkg::IDX_IRQ_ENABLES_A: prdata_reg[7:0] <= irq_en_reg;
				uar_pkg::IDX_TX_STATUS_CTL: prdata_reg[7:0] <= tx_ctl_reg;
				uar_pkg::IDX_BAUD_DIVISOR:  prdata_reg[7:0] <= baud_div_reg;
				default:                    prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Baud divider: one x16 tick every (N+1) or 4(N+1) clocks
	assign reload = tx_ctl_reg[uar_pkg::TCS_HIGH_BAUD] ?
		DIV_WIDTH'(baud_div_reg) :
		DIV_WIDTH'({baud_div_reg, uar_pkg::LOW_SPEED_MUL});
	assign tick16 = port_en && (div_cnt_reg == '0);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_reg <= '0;
		end else if (!port_en || div_cnt_reg == '0) begin
			div_cnt_reg <= reload;
		end else begin
			div_cnt_reg <= div_cnt_reg - 1'b1;
		end
	end

	// Shift clock for synchronous master mode, toggled every other tick
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_phase_reg <= 1'b0;
			sclk_reg       <= 1'b1;
		end else if (!(sync_mode && port_en)) begin
			sclk_phase_reg <= 1'b0;
			sclk_reg       <= 1'b1;
		end else if (tick16) begin
			sclk_phase_reg <= ~sclk_phase_reg;
			if (sclk_phase_reg) begin
				sclk_reg <= ~sclk_reg;
			end
		end
	end

	// ==========================================================
	// Receive pin synchroniser; edge detect looks only at the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_sync_reg <= 2'b11;
			rx_prev_reg <= 1'b1;
		end else begin
			rx_sync_reg <= {rx_sync_reg[0], receive_data_pin_i};
			rx_prev_reg <= rx_sync_reg[1];
		end
	end

	// ==========================================================
	// Bit recovery and frame sequencing
	assign vote_bit  = majority3(votes_reg);
	assign data_bits = rx_ctl_reg[uar_pkg::RCS_NINE_SEL] ?
		uar_pkg::DATA_BITS_9 : uar_pkg::DATA_BITS_8;
	assign word_done = (state_reg == uar_pkg::UAR_STOP) && tick16 &&
		(phase_reg == uar_pkg::VOTE_LAST);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= uar_pkg::UAR_IDLE;
			phase_reg   <= 4'h0;
			bit_cnt_reg <= 4'h0;
			votes_reg   <= 3'h7;
			shift_reg   <= 9'h000;
		end else if (!async_rx_on) begin
			state_reg <= uar_pkg::UAR_IDLE;
			phase_reg <= 4'h0;
		end else begin
			case (state_reg)
				uar_pkg::UAR_IDLE: begin
					if (rx_prev_reg && !rx_sync_reg[1]) begin
						state_reg   <= uar_pkg::UAR_START;
						phase_reg   <= 4'h0;
						bit_cnt_reg <= 4'h0;
						shift_reg   <= 9'h000;
					end
				end
				default: begin
					if (tick16) begin
						phase_reg <= phase_reg + 4'h1;
						if (phase_reg >= uar_pkg::VOTE_FIRST && phase_reg <= uar_pkg::VOTE_LAST) begin
							votes_reg <= {votes_reg[1:0], rx_sync_reg[1]};
						end
						case (state_reg)
							uar_pkg::UAR_START: begin
								// Vote after the third sample; a high start bit is noise
								if (phase_reg == uar_pkg::VOTE_LAST + 4'h1 && vote_bit) begin
									state_reg <= uar_pkg::UAR_IDLE;
								end else if (phase_reg == uar_pkg::OVERSAMPLE_LAST) begin
									state_reg <= uar_pkg::UAR_DATA;
								end
							end
							uar_pkg::UAR_DATA: begin
								if (phase_reg == uar_pkg::OVERSAMPLE_LAST) begin
									// LSB first, eight or nine bits
									if (rx_ctl_reg[uar_pkg::RCS_NINE_SEL]) begin
										shift_reg <= {vote_bit, shift_reg[8:1]};
									end else begin
										shift_reg <= {1'b0, vote_bit, shift_reg[7:1]};
									end
									bit_cnt_reg <= bit_cnt_reg + 4'h1;
									if (bit_cnt_reg + 4'h1 == data_bits) begin
										state_reg <= uar_pkg::UAR_STOP;
									end
								end
							end
							uar_pkg::UAR_STOP: begin
								// Ends at the last vote so the next start edge is not missed
								if (phase_reg == uar_pkg::VOTE_LAST) begin
									state_reg <= uar_pkg::UAR_IDLE;
								end
							end
							default: state_reg <= uar_pkg::UAR_IDLE;
						endcase
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Two-entry receive FIFO with status travelling beside the data
	assign head = fifo_mem[rd_ptr_reg];
	assign pop  = rd_en && (reg_idx == uar_pkg::IDX_RX_BUFFER) && (count_reg != 2'h0);
	assign push = word_done && !overrun_reg && (count_reg != 2'h2 || pop);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fifo_mem[0] <= 10'h000;
			fifo_mem[1] <= 10'h000;
		end else if (push) begin
			fifo_mem[wr_ptr_reg] <= {~majority3({votes_reg[1:0], rx_sync_reg[1]}), shift_reg};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr_reg <= 1'b0;
			wr_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			case ({push, pop})
				2'b10:   count_reg <= count_reg + 2'h1;
				2'b01:   count_reg <= count_reg - 2'h1;
				default: count_reg <= count_reg;
			endcase
		end
	end

	// ==========================================================
	// Overrun: a stop with the FIFO full; cleared only when continuous enable rises again
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			overrun_reg   <= 1'b0;
			cont_en_d_reg <= 1'b0;
		end else begin
			cont_en_d_reg <= rx_ctl_reg[uar_pkg::RCS_CONT_EN];
			if (word_done && count_reg == 2'h2 && !pop) begin
				overrun_reg <= 1'b1;
			end else if (rx_ctl_reg[uar_pkg::RCS_CONT_EN] && !cont_en_d_reg) begin
				overrun_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Interrupt request, level, follows pending gated by its enable
	// pending gated by enable
	assign rx_irq = (count_reg != 2'h0) & irq_en_reg[uar_pkg::IRQ_RX_PENDING];

endmodule
`default_nettype wire

// ==== dv/uar_receiver_monitor.sv ====
// Checker of bus and pin relations of the serial receiver
`timescale 1ns/1ps
`default_nettype none
module uar_receiver_monitor #(
	parameter int DIV_WIDTH = 10
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        receive_data_pin_i,
	input wire logic        receive_data_pin_o,
	input wire logic        receive_data_pin_oe,
	input wire logic        transmit_clock_pin_i,
	input wire logic        transmit_clock_pin_o,
	input wire logic        transmit_clock_pin_oe,
	input wire logic        rx_irq,
	input wire logic        tx_permit
);
	localparam logic [31:0] A_FLG = {22'h0, uar_pkg::IDX_IRQ_FLAGS_A, 2'h0};
	localparam logic [31:0] A_RCS = {22'h0, uar_pkg::IDX_RX_STATUS_CTL, 2'h0};
	localparam logic [31:0] A_IEN = {22'h0, uar_pkg::IDX_IRQ_ENABLES_A, 2'h0};
	localparam logic [31:0] A_TCS = {22'h0, uar_pkg::IDX_TX_STATUS_CTL, 2'h0};
	logic [7:0] rcs_reg;
	logic [7:0] tcs_reg;
	logic [7:0] ien_reg;
	logic       rd_setup;
	logic       mapped;

	// ==========================================================
	// Mirror of the control bits; only the access edge with strobe writes
	assign rd_setup = psel && !penable && !pwrite;
	assign mapped = paddr[1:0] == 2'h0 && paddr[31:10] == 22'h0 && paddr[9:2] inside {
		uar_pkg::IDX_IRQ_FLAGS_A, uar_pkg::IDX_RX_STATUS_CTL, uar_pkg::IDX_TX_BUFFER,
		uar_pkg::IDX_RX_BUFFER, uar_pkg::IDX_IRQ_ENABLES_A, uar_pkg::IDX_TX_STATUS_CTL,
		uar_pkg::IDX_BAUD_DIVISOR};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rcs_reg <= 8'h00;
			tcs_reg <= 8'h00;
			ien_reg <= 8'h00;
		end else if (psel && penable && pwrite && pstrb[0]) begin
			if (paddr == A_RCS) rcs_reg <= pwdata[7:0] & uar_pkg::RCS_WR_MASK;
			if (paddr == A_TCS) tcs_reg <= pwdata[7:0] & uar_pkg::TCS_WR_MASK;
			if (paddr == A_IEN) ien_reg <= pwdata[7:0];
		end
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_rd_setup(logic [31:0] a);
		rd_setup && paddr == a;
	endsequence

	a_irq_gated: assert property (!ien_reg[5] |-> !rx_irq)
		else $error("receive interrupt raised while disabled");
	a_flag_read: assert property (s_rd_setup(A_FLG) ##0 ien_reg[5] |=>
		prdata[7:0] == {2'h0, $past(rx_irq), 5'h0})
		else $error("pending flag read differs from pending state");
	a_rcs_read: assert property (s_rd_setup(A_RCS) |=> prdata[7:3] == rcs_reg[7:3])
		else $error("receive control bits read wrong");
	a_tcs_read: assert property (s_rd_setup(A_TCS) |=> prdata[7:0] == (tcs_reg | 8'h02))
		else $error("transmit control read wrong");
	a_prdata_holds: assert property (!$past(rd_setup) |-> $stable(prdata))
		else $error("read data moved without a read");
	a_clk_owner: assert property (transmit_clock_pin_oe ==
		(rcs_reg[7] && tcs_reg[4] && tcs_reg[7]))
		else $error("shift clock ownership wrong");
	a_clk_idle: assert property (!(rcs_reg[7] && tcs_reg[4]) |=> transmit_clock_pin_o)
		else $error("shift clock not idle high outside synchronous mode");
	a_data_owner: assert property (receive_data_pin_oe |-> rcs_reg[7] && tcs_reg[4])
		else $error("data pin driven outside serial sync mode");
	a_half_duplex: assert property (tcs_reg[4] && rcs_reg[4] |->
		!tx_permit && !receive_data_pin_oe)
		else $error("transmit allowed while receiving");
	a_async_quiet: assert property (!tcs_reg[4] |->
		!receive_data_pin_oe && !transmit_clock_pin_oe)
		else $error("pins driven in asynchronous mode");
	a_slverr_map: assert property (psel && penable |-> pslverr == !mapped)
		else $error("slave error does not match address map");
endmodule
bind uar_receiver uar_receiver_monitor #(.DIV_WIDTH(DIV_WIDTH)) u_mon (.clk(clk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.receive_data_pin_i(receive_data_pin_i), .receive_data_pin_o(receive_data_pin_o),
	.receive_data_pin_oe(receive_data_pin_oe), .transmit_clock_pin_i(transmit_clock_pin_i),
	.transmit_clock_pin_o(transmit_clock_pin_o), .transmit_clock_pin_oe(transmit_clock_pin_oe),
	.rx_irq(rx_irq), .tx_permit(tx_permit));
`default_nettype wire

// ==== dv/uar_serial_src.sv ====
// Remote asynchronous transmitter driving the receive line
`timescale 1ns/1ps
`default_nettype none
module uar_serial_src #(
	parameter int BIT_CLKS = 16
) (
	input  wire logic clk,
	output var logic  line
);
	initial line = 1'b1;

	// ==========================================================
	// start low, data LSB first, one stop bit, then one idle bit
	task automatic send(input logic [8:0] v, input int nb, input logic stop);
		for (int i = 0; i < nb + 3; i++) begin
			line <= (i == 0) ? 1'b0 : (i <= nb) ? v[i-1] : (i == nb + 1) ? stop : 1'b1;
			repeat (BIT_CLKS) @(posedge clk);
		end
	endtask

	// Short low pulse that must not open a frame
	task automatic glitch(input int n);
		line <= 1'b0;
		repeat (n) @(posedge clk);
		line <= 1'b1;
		repeat (2 * BIT_CLKS) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ==== dv/tb_usart_async_receiver.sv ====
// Self-checking bench of the serial receiver
`timescale 1ns/1ps
`default_nettype none
module tb_usart_async_receiver;
	localparam logic [31:0] A_FLG  = {22'h0, uar_pkg::IDX_IRQ_FLAGS_A, 2'h0};
	localparam logic [31:0] A_RCS  = {22'h0, uar_pkg::IDX_RX_STATUS_CTL, 2'h0};
	localparam logic [31:0] A_TXB  = {22'h0, uar_pkg::IDX_TX_BUFFER, 2'h0};
	localparam logic [31:0] A_RXB  = {22'h0, uar_pkg::IDX_RX_BUFFER, 2'h0};
	localparam logic [31:0] A_IEN  = {22'h0, uar_pkg::IDX_IRQ_ENABLES_A, 2'h0};
	localparam logic [31:0] A_TCS  = {22'h0, uar_pkg::IDX_TX_STATUS_CTL, 2'h0};
	localparam logic [31:0] A_BAUD = {22'h0, uar_pkg::IDX_BAUD_DIVISOR, 2'h0};
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata;
	logic [3:0]  pstrb;
	logic        rx_o, rx_oe, ck_o, ck_oe, rx_irq, tx_permit, ser_line, rx_pin, ck_pin;
	int          err_count, total_checks;

	// Shared pins: the far side releases to its idle high level
	assign rx_pin = rx_oe ? rx_o : ser_line;
	assign ck_pin = ck_oe ? ck_o : 1'b1;
	uar_receiver u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .receive_data_pin_i(rx_pin),
		.receive_data_pin_o(rx_o), .receive_data_pin_oe(rx_oe),
		.transmit_clock_pin_i(ck_pin), .transmit_clock_pin_o(ck_o),
		.transmit_clock_pin_oe(ck_oe), .rx_irq(rx_irq), .tx_permit(tx_permit));
	uar_serial_src #(.BIT_CLKS(16)) u_src (.clk(clk), .line(ser_line));

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// Hold the request until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d,
			output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic [31:0] m = '1);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 8'h00, r, e);
		chk(r & m, x);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset_map();
		logic [31:0] r;
		logic        e;
		rd(A_RCS, 32'h00, 32'hFE);
		rd(A_TCS, 32'h02);
		rd(A_FLG, 32'h00);
		rd(A_IEN, 32'h00);
		rd(A_BAUD, 32'h00);
		rd(A_RXB, 32'h00);
		rd(A_TXB, 32'h00);
		wr(A_FLG, 8'hFF);
		rd(A_FLG, 32'h00);
		pstrb <= 4'h0;
		wr(A_BAUD, 8'h33);
		pstrb <= 4'hF;
		rd(A_BAUD, 32'h00);
		apb(1'b0, 32'h0000_0004, 8'h00, r, e);
		chk(32'(e), 32'h1);
		chk(r, 32'h0);
	endtask
	// Setup order, then one frame while continuous receive is off, then a noise pulse
	task automatic t_enable();
		wr(A_BAUD, 8'h00);
		wr(A_TCS, 8'h04);
		wr(A_RCS, 8'h80);
		wr(A_IEN, 8'h20);
		u_src.send(9'h05A, 8, 1'b1);
		rd(A_FLG, 32'h00);
		wr(A_RCS, 8'h90);
		u_src.glitch(3);
		rd(A_FLG, 32'h00);
	endtask
	task automatic t_single();
		u_src.send(9'h0A5, 8, 1'b1);
		chk(32'(rx_irq), 32'h1);
		rd(A_FLG, 32'h20);
		wr(A_IEN, 8'h00);
		chk(32'(rx_irq), 32'h0);
		wr(A_IEN, 8'h20);
		rd(A_RCS, 32'h90);
		rd(A_RXB, 32'hA5);
		rd(A_FLG, 32'h00);
	endtask
	task automatic t_overrun();
		u_src.send(9'h011, 8, 1'b1);
		u_src.send(9'h022, 8, 1'b0);
		u_src.send(9'h033, 8, 1'b1);
		rd(A_RCS, 32'h92);
		rd(A_RXB, 32'h11);
		rd(A_RCS, 32'h96);
		rd(A_RXB, 32'h22);
		rd(A_FLG, 32'h00);
		u_src.send(9'h044, 8, 1'b1);
		rd(A_FLG, 32'h00);
		wr(A_RCS, 8'h80);
		rd(A_RCS, 32'h02, 32'h02);
		wr(A_RCS, 8'h90);
		rd(A_RCS, 32'h00, 32'h02);
		u_src.send(9'h055, 8, 1'b1);
		rd(A_RXB, 32'h55);
	endtask
	task automatic t_nine();
		wr(A_RCS, 8'hD0);
		u_src.send(9'h13C, 9, 1'b1);
		rd(A_RCS, 32'hD1);
		rd(A_RXB, 32'h3C);
		u_src.send(9'h0C3, 9, 1'b1);
		rd(A_RCS, 32'hD0);
		rd(A_RXB, 32'hC3);
	endtask
	task automatic t_sync();
		logic s;
		wr(A_RCS, 8'h80);
		wr(A_TCS, 8'hFF);
		rd(A_TCS, 32'hF7);
		chk(32'(ck_oe), 32'h1);
		// Shift clock toggles once per two ticks; sampled away from the launching edge
		@(negedge clk) s = ck_o;
		repeat (2) @(negedge clk);
		chk(32'(ck_o ^ s), 32'h1);
		@(posedge clk);
		chk(32'(tx_permit), 32'h1);
		chk(32'({rx_oe, rx_o}), 32'h3);
		wr(A_RCS, 8'h90);
		chk(32'({tx_permit, rx_oe}), 32'h0);
		wr(A_TCS, 8'h34);
		chk(32'(ck_oe), 32'h0);
		wr(A_RCS, 8'h80);
		wr(A_TCS, 8'h24);
		chk(32'({rx_oe, ck_oe}), 32'h0);
	endtask

	// ==========================================================
	// Clock, main sequence and watchdog
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pstrb = 4'hF;
		err_count = 0;
		total_checks = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset_map();
		t_enable();
		t_single();
		t_overrun();
		t_nine();
		t_sync();
		tally_and_finish();
	end
	// Nine frames of 176 or 192 clocks each fit well inside this span
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
